// >>> dv/test_trail_trace_unstable_and_indirect_buffer.sv
`timescale 1ns/1ps
`include "ttub_consts.vh"
module test_trail_trace_unstable_and_indirect_buffer;
	reg         ref_clk, rst_b, awvalid, wvalid, bready, arvalid, rready, go, lng;
	reg  [15:0] awaddr, araddr, rnd;
	reg  [31:0] wdata, rdat;
	reg  [2:0]  sgrp, g;
	reg  [1:0]  strib, rresp_v;
	reg  [7:0]  sseed, d;
	reg  [5:0]  b;
	wire        awready, wready, bvalid, arready, rvalid, irq, sbusy, cv, ce, cl;
	wire [1:0]  bresp, rresp, ct;
	wire [31:0] rdata;
	wire [6:0]  alarm;
	wire [2:0]  cg;
	wire [5:0]  ci;
	wire [7:0]  cd;
	integer     bad_count, num_checks, cyc, i, n;
	ttub_trace_buffer i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.cap_valid(cv), .cap_group(cg), .cap_trib(ct), .cap_byte_idx(ci), .cap_data(cd),
		.cap_msg_end(ce), .cap_long_msg(cl), .irq(irq), .trace_unstable_alarm(alarm));
	ttub_stream_src i_src (.ref_clk(ref_clk), .go(go), .grp(sgrp), .trib(strib), .seed(sseed), .lng(lng),
		.busy(sbusy), .cap_valid(cv), .cap_group(cg), .cap_trib(ct), .cap_byte_idx(ci),
		.cap_data(cd), .cap_msg_end(ce), .cap_long_msg(cl));
	always #25 ref_clk = ~ref_clk;
	// Cut a hang short
	always @(posedge ref_clk) begin
		cyc = cyc + 1;
		if (cyc == 8000) begin
			bad_count = bad_count + 1;
			finish_test;
		end
	end
	function [15:0] lfsr(input [15:0] s);
		lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	// Group index kept inside 0 to 6
	function [2:0] grp_of(input [15:0] r);
		grp_of = (r[2:0] == 3'h7) ? 3'h6 : r[2:0];
	endfunction
	// Select readback: unused bits 6:5 read zero
	function [31:0] sel_exp(input [7:0] v);
		sel_exp = {24'h0, v & 8'h9F};
	endfunction
	task finish_test;
		begin
			if (bad_count == 0 && num_checks > 0)
				$display("DONE - PASS");
			else
				$display("DONE - FAIL");
			$finish;
		end
	endtask
	task chk(input [31:0] got, input [31:0] exp);
		begin
			num_checks = num_checks + 1;
			if (got !== exp) begin
				bad_count = bad_count + 1;
				$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	// Write: address and data offered together, each released when taken
	task wr(input [13:0] idx, input [7:0] v);
		begin
			@(posedge ref_clk);
			awaddr <= {idx, 2'b00};
			wdata <= {24'h0, v};
			awvalid <= 1'b1;
			wvalid <= 1'b1;
			bready <= 1'b1;
			n = 0;
			do begin
				@(posedge ref_clk);
				n = n + 1;
				if (awready) awvalid <= 1'b0;
				if (wready) wvalid <= 1'b0;
			end while (!bvalid);
			bready <= 1'b0;
			chk(bresp, `TTUB_RESP_OKAY);
		end
	endtask
	task rd(input [13:0] idx);
		begin
			@(posedge ref_clk);
			araddr <= {idx, 2'b00};
			arvalid <= 1'b1;
			rready <= 1'b1;
			n = 0;
			do begin
				@(posedge ref_clk);
				n = n + 1;
				if (arready) arvalid <= 1'b0;
			end while (!rvalid);
			rdat = rdata;
			rresp_v = rresp;
			rready <= 1'b0;
		end
	endtask
	task rdc(input [13:0] idx, input [31:0] e);
		begin
			rd(idx);
			chk(rdat, e);
		end
	endtask
	// Poll busy until the indirect access ends
	task idle;
		integer k;
		begin
			k = 0;
			rd(`TTUB_IDX_ADDR);
			while (rdat[7] !== 1'b0) begin
				rd(`TTUB_IDX_ADDR);
				k = k + 1;
			end
		end
	endtask
	task start(input [2:0] gr, input [1:0] tr, input [7:0] s);
		begin
			@(posedge ref_clk);
			sgrp <= gr;
			strib <= tr;
			sseed <= s;
			go <= 1'b1;
			@(posedge ref_clk);
			go <= 1'b0;
			@(posedge ref_clk);
		end
	endtask
	// Whole message, then room for alarm and flag to settle
	task send(input [2:0] gr, input [1:0] tr, input [7:0] s);
		begin
			start(gr, tr, s);
			while (sbusy) @(posedge ref_clk);
			repeat (3) @(posedge ref_clk);
		end
	endtask
	initial begin
		{ref_clk, rst_b, awvalid, wvalid, bready, arvalid, rready, go} = 8'h0;
		{awaddr, araddr, wdata, sgrp, strib, sseed} = 77'h0;
		lng = 1'b0;
		bad_count = 0;
		num_checks = 0;
		cyc = 0;
		rnd = 16'hE726;
		repeat (3) @(posedge ref_clk);
		rst_b <= 1'b1;
		rdc(`TTUB_IDX_THRESH, 32'h70);
		rdc(`TTUB_IDX_DATA, 32'h0);
		rd(14'h0F30);
		chk(rresp_v, `TTUB_RESP_SLVERR);
		// Random register values and indirect round trips on both pages
		for (i = 0; i < 6; i = i + 1) begin
			rnd = lfsr(rnd);
			wr(`TTUB_IDX_TRIB, rnd[15:8]);
			rdc(`TTUB_IDX_TRIB, sel_exp(rnd[15:8]));
			wr(`TTUB_IDX_THRESH, rnd[7:0]);
			rdc(`TTUB_IDX_THRESH, rnd[7:0]);
			g = grp_of(rnd);
			b = rnd[13:8];
			d = rnd[7:0] ^ 8'h5A;
			wr(`TTUB_IDX_DATA, d);
			wr(`TTUB_IDX_TRIB, {i[0], 2'b00, g, rnd[4:3]});
			wr(`TTUB_IDX_ADDR, {2'b00, b});
			idle;
			rdc(`TTUB_IDX_DATA, d);
			wr(`TTUB_IDX_DATA, ~d);
			wr(`TTUB_IDX_ADDR, {2'b01, b});
			idle;
			rdc(`TTUB_IDX_DATA, d);
		end
		// Accesses finished, no alarm change yet: only the done bit
		rdc(`TTUB_IDX_IRQ_STAT, 32'h2);
		// Read stalled by live stream lands on the newest byte
		rnd = lfsr(rnd);
		g = grp_of(rnd);
		b = {2'b00, rnd[11:8]};
		d = rnd[7:0] + {2'b00, b};
		wr(`TTUB_IDX_TRIB, {3'b100, g, 2'h1});
		start(g, 2'h1, rnd[7:0]);
		wr(`TTUB_IDX_ADDR, {2'b01, b});
		rd(`TTUB_IDX_ADDR);
		chk(rdat[7], 1'b1);
		idle;
		rdc(`TTUB_IDX_DATA, d);
		// Unstable alarm with short threshold 0
		g = grp_of(lfsr(rnd));
		wr(`TTUB_IDX_THRESH, 8'h70);
		wr(`TTUB_IDX_IRQ_MASK, 8'h01);
		for (i = 0; i < 3; i = i + 1) send(g, 2'h3, 8'h11);
		chk(alarm[g], 1'b0);
		rd(`TTUB_IDX_FLAGS);
		wr(`TTUB_IDX_IRQ_STAT, 8'h03);
		send(g, 2'h3, 8'h22);
		chk(alarm[g], 1'b1);
		chk(irq, 1'b1);
		rdc(`TTUB_IDX_FLAGS, 32'h1 << g);
		rdc(`TTUB_IDX_FLAGS, 32'h0);
		wr(`TTUB_IDX_IRQ_MASK, 8'h00);
		wr(`TTUB_IDX_IRQ_STAT, 8'h03);
		for (i = 0; i < 2; i = i + 1) send(g, 2'h3, 8'h22);
		chk(alarm[g], 1'b0);
		chk(irq, 1'b0);
		rdc(`TTUB_IDX_FLAGS, 32'h1 << g);
		wr(`TTUB_IDX_MODE, 8'h80);
		send(g, 2'h3, 8'h33);
		rdc(`TTUB_IDX_FLAGS, 32'h0);
		wr(`TTUB_IDX_MODE, 8'h01 << g);
		for (i = 0; i < 2; i = i + 1) send(g, 2'h3, 8'h33);
		rdc(`TTUB_IDX_FLAGS, 32'h0);
		// Long threshold 0 declares where short threshold 1 would not
		wr(`TTUB_IDX_MODE, 8'h00);
		wr(`TTUB_IDX_THRESH, 8'h01);
		lng <= 1'b1;
		send(g, 2'h3, 8'h44);
		chk(alarm[g], 1'b1);
		finish_test;
	end
endmodule

// >>> dv/ttub_props.sv
`timescale 1ns/1ps
// Port checks on the trace buffer slice
module ttub_props (
	input wire        ref_clk,
	input wire        rst_b,
	input wire        s_axi_awvalid,
	input wire        s_axi_awready,
	input wire        s_axi_wvalid,
	input wire        s_axi_wready,
	input wire        s_axi_bvalid,
	input wire        s_axi_bready,
	input wire        s_axi_arvalid,
	input wire        s_axi_arready,
	input wire        s_axi_rvalid,
	input wire        s_axi_rready,
	input wire [31:0] s_axi_rdata,
	input wire        cap_valid,
	input wire        cap_msg_end,
	input wire [1:0]  cap_trib,
	input wire        irq,
	input wire [6:0]  trace_unstable_alarm
);
	// Last byte of a fourth-tributary message
	wire tu4_end = cap_valid & cap_msg_end & (cap_trib == 2'h3);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped early");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##[1:2] s_axi_bvalid)
		else $error("write not answered");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
	a_rdata_width: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("read data above byte");
	a_arready_gate: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answer pending");
	a_write_gate: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while answer pending");
	// Alarm may only move right after a fourth-tributary message ends
	a_alarm_cause: assert property ($changed(trace_unstable_alarm) |-> $past(tu4_end) || $past(tu4_end, 2))
		else $error("alarm changed without message");
	c_alarm_rise: cover property ($rose(trace_unstable_alarm != 7'h0));
	c_irq_rise: cover property ($rose(irq));
	c_read_done: cover property (s_axi_rvalid && s_axi_rready);
endmodule
bind ttub_trace_buffer ttub_props i_props (.ref_clk(ref_clk), .rst_b(rst_b),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .cap_valid(cap_valid),
	.cap_msg_end(cap_msg_end), .cap_trib(cap_trib), .irq(irq), .trace_unstable_alarm(trace_unstable_alarm));

// >>> dv/ttub_stream_src.sv
`timescale 1ns/1ps
// Receive trace stream: one 16-byte message per go pulse
module ttub_stream_src (
	input  wire       ref_clk,
	input  wire       go,
	input  wire [2:0] grp,
	input  wire [1:0] trib,
	input  wire [7:0] seed,         // Byte i carries seed plus i
	input  wire       lng,          // Mark the message as 64-byte
	output wire       busy,
	output wire       cap_valid,
	output reg  [2:0] cap_group,
	output reg  [1:0] cap_trib,
	output wire [5:0] cap_byte_idx,
	output wire [7:0] cap_data,
	output wire       cap_msg_end,
	output wire       cap_long_msg
);
	reg [4:0] cnt_reg = 5'h0;       // Bytes still to send
	reg [7:0] seed_reg = 8'h0;
	reg [7:0] junk_reg = 8'h0;      // Idle data moves so stale bytes never look valid
	assign busy = cnt_reg != 5'h0;
	assign cap_valid = busy;
	assign cap_byte_idx = 6'h10 - {1'b0, cnt_reg};
	assign cap_data = busy ? seed_reg + {2'b00, cap_byte_idx} : junk_reg;
	assign cap_msg_end = cnt_reg == 5'h01;
	assign cap_long_msg = lng;
	// Load on go, then count down one byte per cycle
	always @(posedge ref_clk) begin
		junk_reg <= junk_reg + 8'h3B;
		if (go && !busy) begin
			cnt_reg <= 5'h10;
			seed_reg <= seed;
			cap_group <= grp;
			cap_trib <= trib;
		end else if (busy)
			cnt_reg <= cnt_reg - 5'h01;
	end
endmodule

// >>> hdl/ttub_trace_buffer.v
`timescale 1ns/1ps
`include "ttub_consts.vh"
// Contract
// - Fourth-tributary unstable flags latch, read clears
// - Whole-TU3 mode: all flags read zero
// - TU12 group: its flag reads zero
// - Event on each unstable change of a used flag, irq when enabled in the mask
// - Threshold: short bits 3:0, long 7:4
// - Count dissimilar messages, declare above threshold
// - Two identical messages negate the alarm
// - Select: group bits 4:2, tributary 1:0
// - Bit 7 picks capture or expected page
// - Capture page holds latest message unfiltered
// - Both pages readable and writable indirectly
// - Address bits 5:0; write starts access
// - Bit 6: zero writes, one reads
// - Busy high from trigger until done
// - Data holds write until read completes
// - Previous capture page content is the comparison reference
module ttub_trace_buffer (
	input  wire        ref_clk,
	input  wire        rst_b,
	// AXI4-Lite slave
	input  wire [15:0] s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [15:0] s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	// Received trace byte stream
	input  wire        cap_valid,
	input  wire [2:0]  cap_group,
	input  wire [1:0]  cap_trib,
	input  wire [5:0]  cap_byte_idx,
	input  wire [7:0]  cap_data,
	input  wire        cap_msg_end,
	input  wire        cap_long_msg,
	// Interrupt and alarms
	output reg         irq,
	output wire [6:0]  trace_unstable_alarm
);
	localparam ST_IDLE = 2'b01;        // No indirect access
	localparam ST_PEND = 2'b10;        // Access waiting for a free cycle

	// Buffer storage, {group, tributary, page, byte}
	reg  [7:0]  mem [0:`TTUB_BUF_DEPTH-1];
	// Software registers
	reg  [7:0]  unstable_threshold_reg;
	reg  [7:0]  indirect_tributary_select_reg;
	reg  [6:0]  indirect_address_control_reg;
	reg  [7:0]  indirect_data_reg;
	reg  [6:0]  group_unstable_flags_reg;
	reg  [7:0]  mode_config_reg;       // Bit 7 TU3, bits 6:0 TU12 per group
	reg  [1:0]  irq_status_reg;
	reg  [1:0]  irq_mask_reg;
	reg  [1:0]  state_reg;
	reg  [6:0]  diff_acc_reg;          // Per-group message differs so far
	// Write channel holding
	reg  [15:0] aw_addr_reg;
	reg         aw_have_reg;
	reg  [31:0] w_data_reg;
	reg  [3:0]  w_strb_reg;
	reg         w_have_reg;
	// Combinational
	reg  [7:0]  rd_mux;
	reg  [6:0]  flags_next;
	reg  [1:0]  irq_status_next;
	wire        wr_fire;
	wire        rd_fire;
	wire [3:0]  wr_dec;
	wire [3:0]  rd_dec;
	wire        wr_lane0;
	wire [11:0] cap_idx;
	wire [11:0] ind_idx;
	wire [7:0]  cap_old;
	wire        cap_tu4;
	wire        ind_go;
	wire [6:0]  mon_change;
	wire [6:0]  flag_used;
	wire [2:0]  sel_group;
	wire [1:0]  sel_trib;
	wire        sel_page;

	// Register index decode, shared by both channels
	function [3:0] reg_dec;
		input [15:0] addr;
		begin
			case (addr[15:2])
				`TTUB_IDX_FLAGS:    reg_dec = `TTUB_DEC_FLAGS;
				`TTUB_IDX_THRESH:   reg_dec = `TTUB_DEC_THRESH;
				`TTUB_IDX_TRIB:     reg_dec = `TTUB_DEC_TRIB;
				`TTUB_IDX_ADDR:     reg_dec = `TTUB_DEC_ADDR;
				`TTUB_IDX_DATA:     reg_dec = `TTUB_DEC_DATA;
				`TTUB_IDX_MODE:     reg_dec = `TTUB_DEC_MODE;
				`TTUB_IDX_IRQ_STAT: reg_dec = `TTUB_DEC_IRQ_STAT;
				`TTUB_IDX_IRQ_MASK: reg_dec = `TTUB_DEC_IRQ_MASK;
				default:            reg_dec = `TTUB_DEC_NONE;
			endcase
		end
	endfunction

	// Buffer index, shared by capture and indirect paths
	function [11:0] buf_idx;
		input [2:0] grp;
		input [1:0] trib;
		input       page;
		input [5:0] byte_i;
		begin
			buf_idx = {grp, trib, page, byte_i};
		end
	endfunction

	assign wr_fire  = aw_have_reg & w_have_reg & ~s_axi_bvalid;
	assign rd_fire  = s_axi_arvalid & s_axi_arready;
	assign wr_dec   = reg_dec(aw_addr_reg);
	assign rd_dec   = reg_dec(s_axi_araddr);
	assign wr_lane0 = wr_fire & w_strb_reg[0];

	assign sel_group = indirect_tributary_select_reg[4:2];
	assign sel_trib  = indirect_tributary_select_reg[1:0];
	assign sel_page  = indirect_tributary_select_reg[`TTUB_SEL_PAGE_BIT];

	// capture stream always targets the capture page
	assign cap_idx = buf_idx(cap_group, cap_trib, `TTUB_CAP_PAGE, cap_byte_idx);
	assign ind_idx = buf_idx(sel_group, sel_trib, sel_page, indirect_address_control_reg[5:0]);
	assign cap_old = mem[cap_idx];
	assign cap_tu4 = cap_valid & (cap_trib == `TTUB_TU4_INDEX);
	// Stream has priority; indirect access waits a free cycle
	assign ind_go  = state_reg[1] & ~cap_valid;

	// flags not in use in these mappings
	assign flag_used = mode_config_reg[`TTUB_MODE_TU3_BIT] ? 7'h00 : ~mode_config_reg[6:0];

	// Buffer writes; no reset on storage
	always @(posedge ref_clk) begin
		if (cap_valid) begin
			mem[cap_idx] <= cap_data;
		end else if (ind_go && !indirect_address_control_reg[`TTUB_ADDR_RNW_BIT]) begin
			// indirect write, previous capture page is the reference
			mem[ind_idx] <= indirect_data_reg;
		end
	end

	// Per-group differ accumulation for the fourth tributary
	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			diff_acc_reg <= 7'h00;
		end else if (cap_tu4) begin
			if (cap_msg_end) begin
				diff_acc_reg[cap_group] <= 1'b0;
			end else if (cap_old != cap_data) begin
				diff_acc_reg[cap_group] <= 1'b1;
			end
		end
	end

	// One stability monitor per group, fourth tributary
	genvar g;
	generate
		for (g = 0; g < 7; g = g + 1) begin : g_mon
			wire done_g;
			assign done_g = cap_tu4 & cap_msg_end & (cap_group == g);
			ttub_unstable_mon u_mon (
				.ref_clk     (ref_clk),
				.rst_b       (rst_b),
				.msg_done    (done_g),
				.msg_differs (diff_acc_reg[g] | (cap_old != cap_data)),
				.is_long     (cap_long_msg),
				.short_thr   (unstable_threshold_reg[3:0]),
				.long_thr    (unstable_threshold_reg[7:4]),
				.alarm_reg   (trace_unstable_alarm[g]),
				.change_reg  (mon_change[g])
			);
		end
	endgenerate

	// Flag and interrupt status next values, set wins over clear
	always @* begin
		flags_next = group_unstable_flags_reg;
		irq_status_next = irq_status_reg;
		if (rd_fire && rd_dec == `TTUB_DEC_FLAGS) begin
			flags_next = 7'h00;
		end
		// every alarm change of a used flag sets, enable or not
		flags_next = flags_next | (mon_change & flag_used);
		if (wr_lane0 && wr_dec == `TTUB_DEC_IRQ_STAT) begin
			irq_status_next = irq_status_next & ~w_data_reg[1:0];
		end
		if (|(mon_change & flag_used)) begin
			irq_status_next[`TTUB_IRQ_UNST_BIT] = 1'b1;
		end
		if (ind_go) begin
			irq_status_next[`TTUB_IRQ_DONE_BIT] = 1'b1;
		end
	end

	// Software registers and indirect access sequencer
	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			unstable_threshold_reg        <= `TTUB_THRESH_RST;
			indirect_tributary_select_reg <= `TTUB_BYTE_RST;
			indirect_address_control_reg  <= 7'h00;
			indirect_data_reg             <= `TTUB_BYTE_RST;
			mode_config_reg               <= `TTUB_BYTE_RST;
			group_unstable_flags_reg      <= `TTUB_FLAGS_RST;
			irq_status_reg                <= `TTUB_IRQ_RST;
			irq_mask_reg                  <= `TTUB_IRQ_RST;
			state_reg                     <= ST_IDLE;
			irq                           <= 1'b0;
		end else begin
			group_unstable_flags_reg <= flags_next;
			irq_status_reg           <= irq_status_next;
			irq                      <= |(irq_status_next & irq_mask_reg);
			if (wr_lane0) begin
				case (wr_dec)
					`TTUB_DEC_THRESH:   unstable_threshold_reg <= w_data_reg[7:0];
					`TTUB_DEC_TRIB:     indirect_tributary_select_reg <= w_data_reg[7:0] & 8'h9F;
					`TTUB_DEC_MODE:     mode_config_reg <= w_data_reg[7:0];
					`TTUB_DEC_IRQ_MASK: irq_mask_reg <= w_data_reg[1:0];
					default:            irq_mask_reg <= irq_mask_reg;
				endcase
			end
			// software value unless a read completes
			if (ind_go && indirect_address_control_reg[`TTUB_ADDR_RNW_BIT]) begin
				indirect_data_reg <= mem[ind_idx];
			end else if (wr_lane0 && wr_dec == `TTUB_DEC_DATA) begin
				indirect_data_reg <= w_data_reg[7:0];
			end
			case (state_reg)
				ST_IDLE: begin
					if (wr_lane0 && wr_dec == `TTUB_DEC_ADDR) begin
						indirect_address_control_reg <= w_data_reg[6:0];
						state_reg <= ST_PEND;
					end
				end
				ST_PEND: begin
					if (wr_lane0 && wr_dec == `TTUB_DEC_ADDR) begin
						indirect_address_control_reg <= w_data_reg[6:0];
					end else if (ind_go) begin
						state_reg <= ST_IDLE;
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// Read data selection
	always @* begin
		rd_mux = 8'h00;
		case (rd_dec)
			`TTUB_DEC_FLAGS:    rd_mux = {1'b0, group_unstable_flags_reg & flag_used};
			`TTUB_DEC_THRESH:   rd_mux = unstable_threshold_reg;
			`TTUB_DEC_TRIB:     rd_mux = indirect_tributary_select_reg;
			`TTUB_DEC_ADDR:     rd_mux = {state_reg[1], indirect_address_control_reg};
			`TTUB_DEC_DATA:     rd_mux = indirect_data_reg;
			`TTUB_DEC_MODE:     rd_mux = mode_config_reg;
			`TTUB_DEC_IRQ_STAT: rd_mux = {6'h00, irq_status_reg};
			`TTUB_DEC_IRQ_MASK: rd_mux = {6'h00, irq_mask_reg};
			default:            rd_mux = 8'h00;
		endcase
	end

	// AXI write channels, each taken on its own
	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			aw_addr_reg   <= 16'h0000;
			aw_have_reg   <= 1'b0;
			w_data_reg    <= 32'h00000000;
			w_strb_reg    <= 4'h0;
			w_have_reg    <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `TTUB_RESP_OKAY;
		end else begin
			// Ready only while the holding slot is free
			// Also held low while a response is still waiting for bready
			s_axi_awready <= ~aw_have_reg & ~(s_axi_awvalid & s_axi_awready) & ~s_axi_bvalid;
			s_axi_wready  <= ~w_have_reg & ~(s_axi_wvalid & s_axi_wready) & ~s_axi_bvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_addr_reg <= s_axi_awaddr;
				aw_have_reg <= 1'b1;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
				w_have_reg <= 1'b1;
			end
			if (wr_fire) begin
				aw_have_reg  <= 1'b0;
				w_have_reg   <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (wr_dec == `TTUB_DEC_NONE) ? `TTUB_RESP_SLVERR : `TTUB_RESP_OKAY;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// AXI read channel; flags clear on the accepting edge
	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `TTUB_RESP_OKAY;
		end else begin
			s_axi_arready <= ~s_axi_rvalid & ~rd_fire;
			if (rd_fire) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= {24'h000000, rd_mux};
				s_axi_rresp  <= (rd_dec == `TTUB_DEC_NONE) ? `TTUB_RESP_SLVERR : `TTUB_RESP_OKAY;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule

// >>> hdl/ttub_unstable_mon.v
`timescale 1ns/1ps
`include "ttub_consts.vh"
// Trace stability monitor for one tributary
module ttub_unstable_mon (
	input  wire       ref_clk,
	input  wire       rst_b,
	input  wire       msg_done,        // Pulse: one whole message received
	input  wire       msg_differs,     // Message differs from the previous one
	input  wire       is_long,         // Message is 64 bytes, else 16
	input  wire [3:0] short_thr,       // Threshold for 16-byte messages
	input  wire [3:0] long_thr,        // Threshold for 64-byte messages
	output reg        alarm_reg,       // Unstable alarm level
	output reg        change_reg       // Pulse on every alarm change
);
	reg  [4:0] diff_cnt_reg;           // Dissimilar message count
	reg  [1:0] same_cnt_reg;           // Identical repeats after the first
	wire [3:0] thr;                    // Threshold for this length
	wire [4:0] cnt_inc;                // Saturating increment

	assign thr = is_long ? long_thr : short_thr;
	assign cnt_inc = (diff_cnt_reg == `TTUB_CNT_MAX) ? diff_cnt_reg : diff_cnt_reg + 5'h01;

	// Counting, declare and negate
	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			diff_cnt_reg <= 5'h00;
			same_cnt_reg <= 2'h0;
			alarm_reg    <= 1'b0;
			change_reg   <= 1'b0;
		end else begin
			change_reg <= 1'b0;
			if (msg_done && msg_differs) begin
				diff_cnt_reg <= cnt_inc;
				same_cnt_reg <= 2'h0;
				if (!alarm_reg && (cnt_inc > {1'b0, thr})) begin
					alarm_reg  <= 1'b1;
					change_reg <= 1'b1;
				end
			end else if (msg_done) begin
				if (same_cnt_reg == `TTUB_REPEAT_NEED - 2'h1) begin
					same_cnt_reg <= 2'h0;
					diff_cnt_reg <= 5'h00;
					if (alarm_reg) begin
						alarm_reg  <= 1'b0;
						change_reg <= 1'b1;
					end
				end else begin
					same_cnt_reg <= same_cnt_reg + 2'h1;
				end
			end
		end
	end
endmodule

// >>> shared/ttub_consts.vh
`ifndef TTUB_CONSTS_VH
`define TTUB_CONSTS_VH
// Register indices; byte address is four times the index
`define TTUB_IDX_FLAGS     14'h0F27
`define TTUB_IDX_THRESH    14'h0F28
`define TTUB_IDX_TRIB      14'h0F29
`define TTUB_IDX_ADDR      14'h0F2A
`define TTUB_IDX_DATA      14'h0F2B
`define TTUB_IDX_MODE      14'h0F2C
`define TTUB_IDX_IRQ_STAT  14'h0F2D
`define TTUB_IDX_IRQ_MASK  14'h0F2E
// Register decode codes
`define TTUB_DEC_NONE      4'h0
`define TTUB_DEC_FLAGS     4'h1
`define TTUB_DEC_THRESH    4'h2
`define TTUB_DEC_TRIB      4'h3
`define TTUB_DEC_ADDR      4'h4
`define TTUB_DEC_DATA      4'h5
`define TTUB_DEC_MODE      4'h6
`define TTUB_DEC_IRQ_STAT  4'h7
`define TTUB_DEC_IRQ_MASK  4'h8
// Reset values
`define TTUB_THRESH_RST    8'h70
`define TTUB_BYTE_RST      8'h00
`define TTUB_FLAGS_RST     7'h00
`define TTUB_IRQ_RST       2'h0
// Field positions
`define TTUB_SEL_PAGE_BIT  7
`define TTUB_ADDR_RNW_BIT  6
`define TTUB_ADDR_BUSY_BIT 7
`define TTUB_MODE_TU3_BIT  7
`define TTUB_IRQ_UNST_BIT  0
`define TTUB_IRQ_DONE_BIT  1
// Buffer and monitor constants
`define TTUB_CAP_PAGE      1'b1
`define TTUB_TU4_INDEX     2'h3
`define TTUB_REPEAT_NEED   2'h2
`define TTUB_CNT_MAX       5'h1F
`define TTUB_BUF_DEPTH     4096
// AXI responses
`define TTUB_RESP_OKAY     2'h0
`define TTUB_RESP_SLVERR   2'h2
`endif
